// file: rtl/dcsr_consts.svh
// dcsr_consts.svh: offsets, field positions, reset values
// assumes: included by the package and by the register bank
`ifndef DCSR_CONSTS_SVH
`define DCSR_CONSTS_SVH

// ----------------------------------------
// register byte addresses (low 8 bits)
// ----------------------------------------
`define DCSR_AW 8
`define DCSR_A_SCRATCH 8'h00
`define DCSR_A_OE 8'h04
`define DCSR_A_RESTART 8'h08
`define DCSR_A_DIVSYNC 8'h0c
`define DCSR_A_STARTUP 8'h10
`define DCSR_A_CFG 8'h14

// ----------------------------------------
// reset values
// ----------------------------------------
`define DCSR_SCRATCH_RST 32'h0000_0000
`define DCSR_OE_RST 1'h1
`define DCSR_RELATCH_RST 1'h0
`define DCSR_DISOE_RST 1'h1

// ----------------------------------------
// field positions
// ----------------------------------------
`define DCSR_OE_GLOBAL 0
`define DCSR_RS_SOFT 0
`define DCSR_RS_REINIT 1
`define DCSR_DS_ALL 0
`define DCSR_DS_FOD_LO 4
`define DCSR_DS_FOD_HI 6
`define DCSR_DS_OSC 7
`define DCSR_ST_SER_LO 12
`define DCSR_ST_SER_HI 15
`define DCSR_ST_GP_LO 0
`define DCSR_ST_GP_HI 4
`define DCSR_CFG_RELATCH 0
`define DCSR_CFG_DISOE 1

// ----------------------------------------
// sizes
// ----------------------------------------
`define DCSR_NUM_OUT 8
`define DCSR_NUM_GRP 4
`define DCSR_GRP_W 2

`endif

// file: rtl/dcsr_pkg.sv
// dcsr_pkg.sv: types and helpers of the control/status bank
// assumes: dcsr_consts.svh on the include path
`default_nettype none
`include "dcsr_consts.svh"

package dcsr_pkg;

  // sync sequencer states
  typedef enum logic {SEQ_IDLE, SEQ_RUN} dcsr_seq_state_t;

  // one-hot of a divider group index
  function automatic logic [`DCSR_NUM_GRP-1:0] dcsrOneHot(input logic [`DCSR_GRP_W-1:0] idx);
    dcsrOneHot = 4'h1 << idx;
  endfunction

  // lowest set group wins: osc first, then fod0, fod1, fod2
  function automatic logic [`DCSR_GRP_W-1:0] dcsrFirst(input logic [`DCSR_NUM_GRP-1:0] v);
    dcsrFirst = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
  endfunction

endpackage

`default_nettype wire

// file: rtl/dcsr_sync_seq.sv
// dcsr_sync_seq.sv: walks pending divider resyncs one group at a time
// assumes: grpDone is a one-cycle pulse from the divider logic
`timescale 1ns/1ps
`default_nettype none

module dcsr_sync_seq
  import dcsr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`DCSR_NUM_GRP-1:0] setReq,
  input wire logic [`DCSR_NUM_GRP-1:0] grpDone,
  output logic [`DCSR_NUM_GRP-1:0] grpStart,
  output logic [`DCSR_NUM_GRP-1:0] grpActive,
  output logic [`DCSR_NUM_GRP-1:0] pending
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  dcsr_seq_state_t state_r, state_nxt; // idle or one group running
  logic [`DCSR_NUM_GRP-1:0] pend_r, pend_nxt; // requested, not finished
  logic [`DCSR_GRP_W-1:0] cur_r, cur_nxt; // group in progress
  logic [`DCSR_NUM_GRP-1:0] act_r; // running group, one-hot

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic curDone = (state_r == SEQ_RUN) && grpDone[cur_r]; // running group finished
  wire logic [`DCSR_NUM_GRP-1:0] clrMask = curDone ? dcsrOneHot(cur_r) : 4'h0;
  wire logic launch = (state_r == SEQ_IDLE) && (|pend_r); // start next group
  wire logic [`DCSR_GRP_W-1:0] nextGrp = dcsrFirst(pend_r);

  assign pend_nxt = (pend_r & ~clrMask) | setReq;
  assign grpStart = launch ? dcsrOneHot(nextGrp) : 4'h0;
  assign grpActive = act_r;
  assign pending = pend_r;

  // next state
  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    case (state_r)
      SEQ_IDLE: begin
        if (launch) begin // fixed order, lowest first
          state_nxt = SEQ_RUN;
          cur_nxt = nextGrp;
        end
      end
      SEQ_RUN: begin
        if (curDone) begin
          state_nxt = SEQ_IDLE;
        end
      end
      default: state_nxt = SEQ_IDLE;
    endcase
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= SEQ_IDLE;
      pend_r <= 4'h0;
      cur_r <= 2'h0;
      act_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      cur_r <= cur_nxt;
      act_r <= (state_nxt == SEQ_RUN) ? dcsrOneHot(cur_nxt) : 4'h0;
    end
  end

endmodule // dcsr_sync_seq

`default_nettype wire

// file: rtl/dcsr_regs.sv
// dcsr_regs.sv: device control and status register bank on AHB-Lite
// assumes: single clock clk, sync active-low rstn; pins are asynchronous
//
// Operation
// - 32-bit scratch word, reset zero, no effect
// - global enable zero disables every output
// - global enable one: per-output enables rule
// - global enable at bit 0, resets one
// - reinit restarts at calibration, includes divider sync
// - soft restart bit restarts, then self-clears
// - soft restart relatches straps only when allowed
// - bit 7 resyncs oscillator dividers, reads busy
// - bits 6:4 set fractional resyncs, read busy
// - bit 0 syncs all dividers, auto-clears
// - chip-wide sync order: osc, fod0, fod1, fod2
// - master reset rise latches serial pins 15:12
// - same edge latches general pins; 11:5 zero
// - optionally force outputs off while syncing
// - relatch config bit, reset zero
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

`include "dcsr_consts.svh"

module dcsr_regs
  import dcsr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // device pins
  input wire logic masterResetPin,
  input wire logic [3:0] serialPins,
  input wire logic [4:0] generalPins,
  // output driver control
  input wire logic [`DCSR_NUM_OUT-1:0] outIndivEn,
  input wire logic [`DCSR_NUM_OUT*`DCSR_GRP_W-1:0] outGroup,
  output logic [`DCSR_NUM_OUT-1:0] clkOutEn,
  // startup sequencer
  output logic seqRestart,
  output logic seqReinit,
  input wire logic startupSyncReq,
  // divider sync handshake
  input wire logic [`DCSR_NUM_GRP-1:0] grpDone,
  output logic [`DCSR_NUM_GRP-1:0] grpStart,
  output logic [`DCSR_NUM_GRP-1:0] syncActive
);

  // ----------------------------------------
  // bus data phase tracking
  // ----------------------------------------
  logic dpWrite_r; // write data phase pending
  logic dpRead_r; // read data phase pending
  logic rdOk_r; // read data now on hrdata
  logic [`DCSR_AW-1:0] dpAddr_r; // latched byte address
  logic [31:0] hrdata_r; // read data register

  // address and direction are taken only while the slave is ready,
  // so a read wait state never loses the next address phase
  // address phase accepted
  wire logic addrPhase = hsel && hready && htrans[1];
  // reads take one wait state, writes none
  wire logic slvReady = !(dpRead_r && !rdOk_r);
  // the only write strobe into the bank
  wire logic wrFire = dpWrite_r;

  assign hreadyout = slvReady;
  assign hresp = 1'b0; // always okay
  assign hrdata = hrdata_r;

  // latch address phase while ready
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dpWrite_r <= 1'b0;
      dpRead_r <= 1'b0;
      dpAddr_r <= 8'h00;
    end else if (slvReady) begin
      dpWrite_r <= addrPhase && hwrite;
      dpRead_r <= addrPhase && !hwrite;
      dpAddr_r <= haddr[`DCSR_AW-1:0];
    end
  end

  // flag is high for exactly one cycle per read: the cycle in
  // which hrdata stands and hreadyout comes back high
  // read wait-state flag
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdOk_r <= 1'b0;
    end else begin
      rdOk_r <= dpRead_r && !rdOk_r;
    end
  end

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // only the low address byte is decoded; upper bits alias
  wire logic hitScratch = (dpAddr_r == `DCSR_A_SCRATCH);
  wire logic hitOe = (dpAddr_r == `DCSR_A_OE);
  wire logic hitRestart = (dpAddr_r == `DCSR_A_RESTART);
  wire logic hitDivSync = (dpAddr_r == `DCSR_A_DIVSYNC);
  wire logic hitStartup = (dpAddr_r == `DCSR_A_STARTUP);
  wire logic hitCfg = (dpAddr_r == `DCSR_A_CFG);

  // per-register write strobes; startup has none
  wire logic wrScratch = wrFire && hitScratch;
  wire logic wrOe = wrFire && hitOe;
  wire logic wrRestart = wrFire && hitRestart;
  wire logic wrDivSync = wrFire && hitDivSync;
  wire logic wrCfg = wrFire && hitCfg;

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  logic [31:0] scratch_r; // software-only word
  logic oeGlobal_r; // global output enable
  logic relatch_r; // relatch straps on soft restart
  logic disOe_r; // drop outputs while resyncing
  logic reinit_r; // loop reinit bit as written
  logic softBit_r; // soft restart, one cycle
  logic reinitPulse_r; // reinit strobe to sequencer

  // write-one triggers
  wire logic softWr = wrRestart && hwdata[`DCSR_RS_SOFT];
  wire logic reinitWr = wrRestart && hwdata[`DCSR_RS_REINIT];

  // scratch word: stored and read, drives nothing
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scratch_r <= `DCSR_SCRATCH_RST;
    end else if (wrScratch) begin
      scratch_r <= hwdata;
    end
  end

  // global output enable
  always_ff @(posedge clk) begin
    if (!rstn) begin
      oeGlobal_r <= `DCSR_OE_RST;
    end else if (wrOe) begin
      oeGlobal_r <= hwdata[`DCSR_OE_GLOBAL];
    end
  end

  // configuration bits
  always_ff @(posedge clk) begin
    if (!rstn) begin
      relatch_r <= `DCSR_RELATCH_RST;
      disOe_r <= `DCSR_DISOE_RST;
    end else if (wrCfg) begin
      relatch_r <= hwdata[`DCSR_CFG_RELATCH];
      disOe_r <= hwdata[`DCSR_CFG_DISOE];
    end
  end

  // reinit is kept as written so software reads back its request;
  // the startup sequencer only ever sees the one-cycle strobe
  // reinit bit keeps its written value
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reinit_r <= 1'b0;
    end else if (wrRestart) begin
      reinit_r <= hwdata[`DCSR_RS_REINIT];
    end
  end

  // restart strobes; soft bit clears itself after one cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      softBit_r <= 1'b0;
      reinitPulse_r <= 1'b0;
    end else begin
      softBit_r <= softWr;
      reinitPulse_r <= reinitWr;
    end
  end

  assign seqRestart = softBit_r;
  assign seqReinit = reinitPulse_r;

  // ----------------------------------------
  // divider resync requests
  // ----------------------------------------
  logic divAll_r; // chip-wide sync in progress
  logic [`DCSR_NUM_GRP-1:0] seqPend; // groups not yet resynced
  logic [`DCSR_NUM_GRP-1:0] seqStart; // group launch strobes
  logic [`DCSR_NUM_GRP-1:0] seqActive; // group now resyncing

  // a chip-wide request just marks every group pending; the
  // sequencer then walks them in its fixed order
  // chip-wide trigger: software bit or restarted startup
  wire logic allTrig = (wrDivSync && hwdata[`DCSR_DS_ALL]) || startupSyncReq;
  // group 0 oscillator, groups 1..3 fractional dividers 0..2
  wire logic [`DCSR_NUM_GRP-1:0] swSet = wrDivSync ?
    {hwdata[`DCSR_DS_FOD_HI:`DCSR_DS_FOD_LO], hwdata[`DCSR_DS_OSC]} : 4'h0;
  wire logic [`DCSR_NUM_GRP-1:0] grpSet = swSet | {`DCSR_NUM_GRP{allTrig}};

  // chip-wide flag: set wins, clears when nothing pending
  always_ff @(posedge clk) begin
    if (!rstn) begin
      divAll_r <= 1'b0;
    end else if (allTrig) begin
      divAll_r <= 1'b1;
    end else if (!(|seqPend)) begin
      divAll_r <= 1'b0;
    end
  end

  // runs pending groups one at a time in fixed order
  dcsr_sync_seq u_seq (
    .clk(clk),
    .rstn(rstn),
    .setReq(grpSet),
    .grpDone(grpDone),
    .grpStart(seqStart),
    .grpActive(seqActive),
    .pending(seqPend)
  );

  assign grpStart = seqStart;
  assign syncActive = seqActive;

  // ----------------------------------------
  // pin synchronisers and strap capture
  // ----------------------------------------
  logic mrMeta_r, mrSync_r, mrDly_r; // master reset pin
  logic [3:0] serMeta_r, serSync_r; // serial pins
  logic [4:0] gpMeta_r, gpSync_r; // general pins
  logic [3:0] serCap_r; // latched serial levels
  logic [4:0] gpCap_r; // latched general levels

  // straps are taken from the second stage only, so a first stage
  // that is still settling is never latched into status
  // two flops per pin before any use
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mrMeta_r <= 1'b0;
      mrSync_r <= 1'b0;
      mrDly_r <= 1'b0;
      serMeta_r <= 4'h0;
      serSync_r <= 4'h0;
      gpMeta_r <= 5'h00;
      gpSync_r <= 5'h00;
    end else begin
      mrMeta_r <= masterResetPin;
      mrSync_r <= mrMeta_r;
      mrDly_r <= mrSync_r;
      serMeta_r <= serialPins;
      serSync_r <= serMeta_r;
      gpMeta_r <= generalPins;
      gpSync_r <= gpMeta_r;
    end
  end

  // a pin already high when rstn lifts reads as a rising edge and
  // captures, as a part leaving reset with the pin up would
  // rising edge of the synchronised master reset
  wire logic mrRise = mrSync_r && !mrDly_r;
  // soft restart relatches only if configured
  wire logic relatchNow = softWr && relatch_r;
  wire logic capture = mrRise || relatchNow;

  // strap capture registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      serCap_r <= 4'h0;
      gpCap_r <= 5'h00;
    end else if (capture) begin
      serCap_r <= serSync_r;
      gpCap_r <= gpSync_r;
    end
  end

  // ----------------------------------------
  // output enable gating
  // ----------------------------------------
  logic [`DCSR_NUM_OUT-1:0] oeNxt; // combined enable per output
  logic [`DCSR_NUM_OUT-1:0] clkOutEn_r; // registered enables

  // per output: global, own enable, resync blanking
  genvar gi;
  generate
    for (gi = 0; gi < `DCSR_NUM_OUT; gi = gi + 1) begin : g_oe
      wire logic [`DCSR_GRP_W-1:0] grp = outGroup[gi*`DCSR_GRP_W +: `DCSR_GRP_W];
      wire logic blank = disOe_r && seqActive[grp];
      assign oeNxt[gi] = oeGlobal_r && outIndivEn[gi] && !blank;
    end
  endgenerate

  // registering keeps glitches of group select and sequencer
  // state off the output drivers, at one cycle of latency
  // register the driver enables
  always_ff @(posedge clk) begin
    if (!rstn) begin
      clkOutEn_r <= {`DCSR_NUM_OUT{1'b0}};
    end else begin
      clkOutEn_r <= oeNxt;
    end
  end

  assign clkOutEn = clkOutEn_r;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // restart readback: soft bit shows its one-cycle life
  wire logic [31:0] rdRestart = {30'h0, reinit_r, softBit_r};
  // busy bits read one until their group finishes
  wire logic [31:0] rdDivSync =
    {24'h0, seqPend[0], seqPend[3:1], 3'h0, divAll_r};
  // status: reserved 11:5 read zero
  wire logic [31:0] rdStartup = {16'h0, serCap_r, 7'h00, gpCap_r};
  wire logic [31:0] rdOe = {31'h0, oeGlobal_r};
  wire logic [31:0] rdCfg = {30'h0, disOe_r, relatch_r};

  // reserved fields are zero padding here, never stored
  // unmapped addresses read zero
  wire logic [31:0] rdMux =
    hitScratch ? scratch_r :
    hitOe ? rdOe :
    hitRestart ? rdRestart :
    hitDivSync ? rdDivSync :
    hitStartup ? rdStartup :
    hitCfg ? rdCfg : 32'h0;

  // load read data in the wait-state cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hrdata_r <= 32'h0;
    end else if (dpRead_r && !rdOk_r) begin
      hrdata_r <= rdMux;
    end
  end

endmodule // dcsr_regs

`default_nettype wire

// file: bench/dcsr_regs_assertions.sv
// dcsr_regs_assertions.sv: concurrent checks on the register bank ports
// assumes: bound to dcsr_regs, one clock, sync active-low reset
`timescale 1ns/1ps
`default_nettype none

`include "dcsr_consts.svh"

module dcsr_regs_chk
  import dcsr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [`DCSR_NUM_OUT-1:0] outIndivEn,
  input wire logic [`DCSR_NUM_OUT-1:0] clkOutEn,
  input wire logic seqRestart,
  input wire logic seqReinit,
  input wire logic [`DCSR_NUM_GRP-1:0] grpDone,
  input wire logic [`DCSR_NUM_GRP-1:0] grpStart,
  input wire logic [`DCSR_NUM_GRP-1:0] syncActive
);
  // ----------------------------------------
  // helper decode
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic rstPhase_r; // data phase of a restart write
  wire takeRst = hsel & hready & htrans[1] & hwrite & (haddr[7:0] == `DCSR_A_RESTART);
  wire takeRd = hsel & hready & htrans[1] & ~hwrite;
  // track the restart write into its data phase
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rstPhase_r <= 1'b0;
    end else if (hready) begin
      rstPhase_r <= takeRst;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_read_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (takeRd |=> s_read_wait)
    else $error("read data phase wait wrong");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_restart_pulse: assert property (seqRestart == $past(rstPhase_r & hwdata[`DCSR_RS_SOFT]))
    else $error("restart pulse not tied to write");
  a_reinit_pulse: assert property (seqReinit == $past(rstPhase_r & hwdata[`DCSR_RS_REINIT]))
    else $error("reinit pulse not tied to write");
  a_oe_gated: assert property ((clkOutEn & ~$past(outIndivEn)) == 8'h00)
    else $error("output enabled without own enable");
  a_sync_onehot: assert property ($onehot0(syncActive) && $onehot0(grpStart))
    else $error("more than one group syncing");
  a_start_active: assert property (grpStart != 4'h0 |=> syncActive == $past(grpStart))
    else $error("started group not active");
  a_active_hold: assert property (syncActive != 4'h0 && (grpDone & syncActive) == 4'h0
    |=> syncActive == $past(syncActive))
    else $error("group dropped before done");
  a_done_ends: assert property ((grpDone & syncActive) != 4'h0
    |=> (syncActive & $past(syncActive)) == 4'h0)
    else $error("group still active after done");
endmodule // dcsr_regs_chk

bind dcsr_regs dcsr_regs_chk u_chk (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .outIndivEn(outIndivEn), .clkOutEn(clkOutEn), .seqRestart(seqRestart),
  .seqReinit(seqReinit), .grpDone(grpDone), .grpStart(grpStart), .syncActive(syncActive));

`default_nettype wire

// file: bench/tb_top.sv
// tb_top.sv: self-checking bench for the control/status register bank
// assumes: package and checker compiled first; bus master in the bench
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk = 1'b0;
  logic rstn, hwrite, hreadyout, hresp, masterResetPin, seqRestart, seqReinit, startupSyncReq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [3:0] serialPins, grpDone, grpStart, syncActive;
  logic [4:0] generalPins;
  logic [7:0] outIndivEn, clkOutEn;
  logic [15:0] outGroup;
  int badCount = 0;
  int totalChecks = 0;

  dcsr_regs DUT (.clk(clk), .rstn(rstn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .masterResetPin(masterResetPin),
    .serialPins(serialPins), .generalPins(generalPins), .outIndivEn(outIndivEn),
    .outGroup(outGroup), .clkOutEn(clkOutEn), .seqRestart(seqRestart), .seqReinit(seqReinit),
    .startupSyncReq(startupSyncReq), .grpDone(grpDone), .grpStart(grpStart),
    .syncActive(syncActive));

  always #2 clk = ~clk;

  // ----------------------------------------
  // report and compare
  // ----------------------------------------
  task automatic wrapUp;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ----------------------------------------
  // ahb-lite master
  // ----------------------------------------
  // settled hready before an edge, then take that edge
  task automatic waitRdy(output logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1 && n < 64) begin
      @(negedge clk);
      n++;
    end
    if (hreadyout !== 1'b1) begin
      badCount++;
      wrapUp();
    end
    d = hrdata;
    @(posedge clk);
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    waitRdy(rd);
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy(rd);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk("hrdata", rd, e);
  endtask

  // finish one group resync: active flag, outputs off if blanking, then done
  task automatic serveGroup(input int g, input logic blankOn);
    int n;
    logic [7:0] expOe;
    n = 0;
    expOe = blankOn ? ~(8'h11 << g) : 8'hff;
    @(negedge clk);
    while (syncActive === 4'h0 && n < 64) begin
      @(negedge clk);
      n++;
    end
    if (syncActive === 4'h0) begin
      badCount++;
      wrapUp();
    end
    chk("syncActive", syncActive, 32'h1 << g);
    @(negedge clk);
    chk("clkOutEn", clkOutEn, expOe);
    @(posedge clk);
    grpDone <= 4'h1 << g;
    @(posedge clk);
    grpDone <= 4'h0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic testReset;
    rdChk(8'h00, 32'h0);
    rdChk(8'h04, 32'h1);
    rdChk(8'h0c, 32'h0);
    rdChk(8'h14, 32'h2);
    rdChk(8'h10, 32'h0);
    chk("clkOutEn", clkOutEn, outIndivEn);
  endtask

  task automatic testScratchOe;
    xfer(8'h00, 1'b1, 32'ha5a5_5a5a);
    xfer(8'h18, 1'b1, 32'hffff_ffff);
    rdChk(8'h18, 32'h0);
    rdChk(8'h00, 32'ha5a5_5a5a);
    xfer(8'h04, 1'b1, 32'h0);
    rdChk(8'h04, 32'h0);
    chk("clkOutEn", clkOutEn, 32'h0);
    xfer(8'h04, 1'b1, 32'hffff_ffff);
    rdChk(8'h04, 32'h1);
    chk("clkOutEn", clkOutEn, 32'h5a);
  endtask

  task automatic testStraps;
    @(posedge clk);
    serialPins <= 4'ha;
    generalPins <= 5'h15;
    repeat (2) @(posedge clk);
    masterResetPin <= 1'b1;
    repeat (8) @(posedge clk);
    rdChk(8'h10, 32'ha015);
    xfer(8'h10, 1'b1, 32'hffff_ffff);
    rdChk(8'h10, 32'ha015);
    serialPins <= 4'h5;
    generalPins <= 5'h0a;
    xfer(8'h08, 1'b1, 32'h1);
    @(negedge clk);
    chk("seqRestart", seqRestart, 32'h1);
    @(negedge clk);
    chk("seqRestart", seqRestart, 32'h0);
    rdChk(8'h08, 32'h0);
    rdChk(8'h10, 32'ha015);
    xfer(8'h14, 1'b1, 32'h3);
    xfer(8'h08, 1'b1, 32'h1);
    rdChk(8'h10, 32'h500a);
    xfer(8'h08, 1'b1, 32'h2);
    @(negedge clk);
    chk("seqReinit", seqReinit, 32'h1);
    rdChk(8'h08, 32'h2);
  endtask

  task automatic testSync;
    outIndivEn <= 8'hff;
    xfer(8'h0c, 1'b1, 32'h1);
    for (int g = 0; g < 4; g++) begin
      serveGroup(g, 1'b1);
    end
    repeat (2) @(posedge clk);
    rdChk(8'h0c, 32'h0);
    xfer(8'h0c, 1'b1, 32'hf0);
    rdChk(8'h0c, 32'hf0);
    serveGroup(0, 1'b1);
    rdChk(8'h0c, 32'h70);
    for (int g = 1; g < 4; g++) begin
      serveGroup(g, 1'b1);
    end
    repeat (2) @(posedge clk);
    rdChk(8'h0c, 32'h0);
    startupSyncReq <= 1'b1;
    @(posedge clk);
    startupSyncReq <= 1'b0;
    rdChk(8'h0c, 32'hf1);
    for (int g = 0; g < 4; g++) begin
      serveGroup(g, 1'b1);
    end
    xfer(8'h14, 1'b1, 32'h1);
    xfer(8'h0c, 1'b1, 32'h80);
    serveGroup(0, 1'b0);
    rdChk(8'h0c, 32'h0);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    masterResetPin = 1'b0;
    serialPins = 4'h0;
    generalPins = 5'h0;
    outIndivEn = 8'h5a;
    outGroup = 16'he4e4;
    startupSyncReq = 1'b0;
    grpDone = 4'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    testReset();
    testScratchOe();
    testStraps();
    testSync();
    wrapUp();
  end
endmodule // tb_top

`default_nettype wire
